// file: hw/gtm_defines.svh
// Register offsets, field positions, reset values and constants of the tag/length/gap block
`ifndef GTM_DEFINES_SVH
`define GTM_DEFINES_SVH
// ==========================================
// Register byte addresses
`define GTM_ADDR_MODE 12'h004
`define GTM_ADDR_MAXLEN 12'h008
`define GTM_ADDR_TAGS 12'h00c
`define GTM_ADDR_ADVCHK 12'h010
`define GTM_ADDR_IFG 12'h014
`define GTM_ADDR_STATUS 12'h030
// ==========================================
// Field positions
`define GTM_MODE_FDX 0
`define GTM_MODE_GIGA 4
`define GTM_TAGS_OUTER 0
`define GTM_TAGS_INNER 1
`define GTM_TAGS_LENADJ 2
`define GTM_ADV_DROP 0
`define GTM_TAGS_TPID 16
`define GTM_IFG_TX 8
`define GTM_IFG_RX2 4
`define GTM_IFG_RX1 0
// ==========================================
// Reset values
`define GTM_RST_MODE 32'h0000_0011
`define GTM_RST_MAXLEN 32'h0000_05ee
`define GTM_RST_TAGS 32'h8100_0004
`define GTM_RST_ADVCHK 32'h0000_0000
`define GTM_RST_IFG 32'h0000_0715
// ==========================================
// Implemented bits of each register
`define GTM_MASK_MODE 32'h0000_0011
`define GTM_MASK_MAXLEN 32'h0000_ffff
`define GTM_MASK_TAGS 32'hffff_0007
`define GTM_MASK_ADVCHK 32'h0000_0001
`define GTM_MASK_IFG 32'h0000_1fff
// ==========================================
// Frame constants and bus response codes
`define GTM_STD_TPID 16'h8100
`define GTM_SFD 8'hd5
`define GTM_TYPE_POS 16'h000d
`define GTM_TAG_BYTES 16'h0004
`define GTM_HDR_FCS 16'h0012
`define GTM_MAX_LENFLD 16'h05dc
`define GTM_RESP_OK 2'b00
`define GTM_RESP_SLVERR 2'b10
`endif

// file: hw/gtm_pkg.sv
// Types shared by the tag/length/gap block and its testbench
package gtm_pkg;
   // One receive byte with frame marks
   typedef struct packed {
      logic err;
      logic last;
      logic [7:0] data;
   } gtm_word_t;
   // Configuration fields seen by the datapath
   typedef struct packed {
      logic [15:0] custom_tpid;
      logic outer_tag_aware_en;
      logic inner_tag_aware_en;
      logic tag_length_allow_en;
      logic length_error_drop_en;
      logic [15:0] max_frame_bytes;
   } gtm_cfg_t;
   // Inter-frame gap settings driven to the MAC timing logic
   typedef struct packed {
      logic [4:0] tx_gap_len;
      logic [3:0] rx_gap_part2;
      logic [3:0] rx_gap_part1;
      logic gigabit_speed_sel;
      logic full_duplex_sel;
   } gtm_gap_t;
   typedef enum logic [2:0] {
      GTM_IDLE = 3'b001,
      GTM_DATA = 3'b010,
      GTM_DROP = 3'b100
   } gtm_rx_state_t;
endpackage

// file: hw/gtm_fifo.sv
// Receive byte FIFO with registered read data and valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module gtm_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_size
      $error("gtm_fifo: WIDTH must be positive and DEPTH a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
   logic [AW:0] cnt_q, cnt_d;
   logic [WIDTH-1:0] out_q, out_d;
   logic ov_q, ov_d, rdy_q, rdy_d;
   logic push, pop;
   always_comb begin
      push = in_valid && rdy_q;
      pop = (cnt_q != '0) && (!ov_q || out_ready);
      wptr_d = push ? wptr_q + 1'b1 : wptr_q;
      rptr_d = pop ? rptr_q + 1'b1 : rptr_q;
      cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      rdy_d = cnt_d < (AW + 1)'(DEPTH);
      out_d = pop ? mem[rptr_q] : out_q;
      ov_d = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
         out_q <= '0;
         ov_q <= 1'b0;
         rdy_q <= 1'b1;
      end else begin
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         cnt_q <= cnt_d;
         out_q <= out_d;
         ov_q <= ov_d;
         rdy_q <= rdy_d;
      end
   end
   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wptr_q] <= in_data;
      end
   end
   assign in_ready = rdy_q;
   assign out_data = out_q;
   assign out_valid = ov_q;
endmodule
`default_nettype wire

// file: hw/gtm_mac_cfg.sv
// Tag recognition, length checking and gap configuration of one MAC port
`timescale 1ns/10ps
`default_nettype none
`include "gtm_defines.svh"
// How it works
// - A TPID is 0x8100 or the programmed identifier, at every tag position.
// - Outer awareness off: no tags seen; on: accept outer tag with either TPID.
// - Inner awareness off: no inner tags; on, with outer awareness also on: accept inner tag with either TPID.
// - With length adjust on, one tag allows 4 bytes, two tags 8 bytes.
// - Maximum frame length is 16 bits, reset 0x05EE, plus tag allowance.
// - Length drop enabled discards frames with length errors; reset leaves it off.
// - Transmit gap is a 5-bit field, reset 0x07.
// - Receive gap second part is a 4-bit field, reset 0x1.
// - Receive gap first part is a 4-bit field, reset 0x5.
// - Speed bit picks gigabit, duplex bit full duplex; gigabit needs full duplex.
module gtm_mac_cfg #(
   parameter int FIFO_DEPTH = 32
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // GMII receive
   input wire logic [7:0] gmii_rxd,
   input wire logic gmii_rx_dv,
   input wire logic gmii_rx_er,
   // Receive stream to switch core
   output gtm_pkg::gtm_word_t rx_word,
   output logic rx_valid,
   input wire logic rx_ready,
   // Transmit gap timing
   input wire logic tx_frame_done,
   output logic tx_gap_busy,
   output gtm_pkg::gtm_gap_t gap_cfg
);
   import gtm_pkg::*;
   // ==========================================
   // Functions
   function automatic logic is_tpid(input logic [15:0] et, input logic [15:0] cust);
      is_tpid = (et == `GTM_STD_TPID) || (et == cust);
   endfunction
   function automatic logic [15:0] tag_bytes(input logic [1:0] n);
      tag_bytes = n[1] ? `GTM_TAG_BYTES + `GTM_TAG_BYTES : (n[0] ? `GTM_TAG_BYTES : 16'h0000);
   endfunction
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
      end
   endfunction
   // ==========================================
   // Register bus
   logic [31:0] mode_q, mode_d, maxlen_q, maxlen_d, tags_q, tags_d;
   logic [31:0] adv_q, adv_d, ifg_q, ifg_d, rdata_q, rdata_d;
   logic [11:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic awf_q, awf_d, wf_q, wf_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [15:0] drop_cnt_q, ovs_cnt_q;
   logic do_write;
   always_comb begin
      awf_d = awf_q || (s_axi_awvalid && awrdy_q);
      awaddr_d = (s_axi_awvalid && awrdy_q) ? s_axi_awaddr : awaddr_q;
      wf_d = wf_q || (s_axi_wvalid && wrdy_q);
      wdata_d = (s_axi_wvalid && wrdy_q) ? s_axi_wdata : wdata_q;
      wstrb_d = (s_axi_wvalid && wrdy_q) ? s_axi_wstrb : wstrb_q;
      do_write = awf_q && wf_q && !bvalid_q;
      mode_d = mode_q;
      maxlen_d = maxlen_q;
      tags_d = tags_q;
      adv_d = adv_q;
      ifg_d = ifg_q;
      bresp_d = bresp_q;
      bvalid_d = bvalid_q && !s_axi_bready;
      if (do_write) begin
         awf_d = 1'b0;
         wf_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = `GTM_RESP_OK;
         case (awaddr_q)
            `GTM_ADDR_MODE: mode_d = merge(mode_q, wdata_q, wstrb_q);
            `GTM_ADDR_MAXLEN: maxlen_d = merge(maxlen_q, wdata_q, wstrb_q);
            `GTM_ADDR_TAGS: tags_d = merge(tags_q, wdata_q, wstrb_q);
            `GTM_ADDR_ADVCHK: adv_d = merge(adv_q, wdata_q, wstrb_q);
            `GTM_ADDR_IFG: ifg_d = merge(ifg_q, wdata_q, wstrb_q);
            `GTM_ADDR_STATUS: bresp_d = `GTM_RESP_OK;
            default: bresp_d = `GTM_RESP_SLVERR;
         endcase
      end
      // Only implemented bits are kept; the rest read as zero
      mode_d = mode_d & `GTM_MASK_MODE;
      maxlen_d = maxlen_d & `GTM_MASK_MAXLEN;
      tags_d = tags_d & `GTM_MASK_TAGS;
      adv_d = adv_d & `GTM_MASK_ADVCHK;
      ifg_d = ifg_d & `GTM_MASK_IFG;
      awrdy_d = !awf_d && !bvalid_d;
      wrdy_d = !wf_d && !bvalid_d;
      rvalid_d = rvalid_q && !s_axi_rready;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (s_axi_arvalid && arrdy_q) begin
         rvalid_d = 1'b1;
         rresp_d = `GTM_RESP_OK;
         case (s_axi_araddr)
            `GTM_ADDR_MODE: rdata_d = mode_q;
            `GTM_ADDR_MAXLEN: rdata_d = maxlen_q;
            `GTM_ADDR_TAGS: rdata_d = tags_q;
            `GTM_ADDR_ADVCHK: rdata_d = adv_q;
            `GTM_ADDR_IFG: rdata_d = ifg_q;
            `GTM_ADDR_STATUS: rdata_d = {drop_cnt_q, ovs_cnt_q};
            default: begin
               rdata_d = 32'h0000_0000;
               rresp_d = `GTM_RESP_SLVERR;
            end
         endcase
      end
      arrdy_d = !rvalid_d;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         maxlen_q <= `GTM_RST_MAXLEN;
         mode_q <= `GTM_RST_MODE;
         tags_q <= `GTM_RST_TAGS;
         adv_q <= `GTM_RST_ADVCHK;
         ifg_q <= `GTM_RST_IFG;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         awf_q <= 1'b0;
         wf_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `GTM_RESP_OK;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `GTM_RESP_OK;
         awrdy_q <= 1'b1;
         wrdy_q <= 1'b1;
         arrdy_q <= 1'b1;
      end else begin
         maxlen_q <= maxlen_d;
         mode_q <= mode_d;
         tags_q <= tags_d;
         adv_q <= adv_d;
         ifg_q <= ifg_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         awf_q <= awf_d;
         wf_q <= wf_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         awrdy_q <= awrdy_d;
         wrdy_q <= wrdy_d;
         arrdy_q <= arrdy_d;
      end
   end
   assign s_axi_awready = awrdy_q;
   assign s_axi_wready = wrdy_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arrdy_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   // ==========================================
   // Configuration view
   gtm_cfg_t cfg;
   gtm_gap_t gap_q, gap_d;
   always_comb begin
      cfg.custom_tpid = tags_q[`GTM_TAGS_TPID +: 16];
      cfg.outer_tag_aware_en = tags_q[`GTM_TAGS_OUTER];
      // inner awareness only counts with outer awareness on
      cfg.inner_tag_aware_en = tags_q[`GTM_TAGS_INNER] && tags_q[`GTM_TAGS_OUTER];
      cfg.tag_length_allow_en = tags_q[`GTM_TAGS_LENADJ];
      cfg.length_error_drop_en = adv_q[`GTM_ADV_DROP];
      cfg.max_frame_bytes = maxlen_q[15:0];
      gap_d.tx_gap_len = ifg_q[`GTM_IFG_TX +: 5];
      gap_d.rx_gap_part2 = ifg_q[`GTM_IFG_RX2 +: 4];
      gap_d.rx_gap_part1 = ifg_q[`GTM_IFG_RX1 +: 4];
      // gigabit only together with full duplex
      gap_d.full_duplex_sel = mode_q[`GTM_MODE_FDX];
      gap_d.gigabit_speed_sel = mode_q[`GTM_MODE_GIGA] && mode_q[`GTM_MODE_FDX];
   end
   // ==========================================
   // Transmit gap timer
   logic [4:0] gap_cnt_q, gap_cnt_d;
   logic busy_q, busy_d;
   always_comb begin
      gap_cnt_d = gap_cnt_q;
      busy_d = busy_q;
      if (tx_frame_done) begin
         gap_cnt_d = gap_q.tx_gap_len;
         busy_d = gap_q.tx_gap_len != 5'h00;
      end else if (busy_q) begin
         gap_cnt_d = gap_cnt_q - 5'h01;
         busy_d = gap_cnt_q != 5'h01;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap_cnt_q <= '0;
         busy_q <= 1'b0;
         gap_q <= '0;
      end else begin
         gap_cnt_q <= gap_cnt_d;
         busy_q <= busy_d;
         gap_q <= gap_d;
      end
   end
   assign tx_gap_busy = busy_q;
   assign gap_cfg = gap_q;
   // ==========================================
   // Receive parser
   gtm_rx_state_t st_q, st_d;
   logic [15:0] cnt_q, cnt_d, lenfld_q, lenfld_d, limit;
   logic [7:0] hi_q, hi_d, hold_q, hold_d;
   logic [1:0] ntag_q, ntag_d;
   logic ovs_q, ovs_d, err_q, err_d, have_q, have_d;
   logic [15:0] drop_cnt_d, ovs_cnt_d;
   gtm_word_t push_word;
   logic push, fifo_rdy, in_range_err, frame_bad;
   always_comb begin
      limit = cfg.max_frame_bytes + (cfg.tag_length_allow_en ? tag_bytes(ntag_q) : 16'h0000);
      in_range_err = (lenfld_q <= `GTM_MAX_LENFLD)
                     && (cnt_q < `GTM_HDR_FCS + tag_bytes(ntag_q) + lenfld_q);
      frame_bad = ovs_q || err_q || in_range_err;
      st_d = st_q;
      cnt_d = cnt_q;
      lenfld_d = lenfld_q;
      hi_d = hi_q;
      hold_d = hold_q;
      ntag_d = ntag_q;
      ovs_d = ovs_q;
      err_d = err_q;
      have_d = have_q;
      drop_cnt_d = drop_cnt_q;
      ovs_cnt_d = ovs_cnt_q;
      push = 1'b0;
      push_word = '{err: 1'b0, last: 1'b0, data: hold_q};
      case (st_q)
         GTM_IDLE: begin
            if (gmii_rx_dv && gmii_rxd == `GTM_SFD) begin
               st_d = GTM_DATA;
               cnt_d = '0;
               ntag_d = '0;
               ovs_d = 1'b0;
               err_d = 1'b0;
               have_d = 1'b0;
               lenfld_d = 16'hffff;
            end
         end
         GTM_DATA, GTM_DROP: begin
            if (gmii_rx_dv) begin
               cnt_d = (cnt_q == 16'hffff) ? cnt_q : cnt_q + 16'h0001;
               hi_d = gmii_rxd;
               err_d = err_q || gmii_rx_er;
               if (cnt_q == `GTM_TYPE_POS + tag_bytes(ntag_q)) begin
                  if (is_tpid({hi_q, gmii_rxd}, cfg.custom_tpid)
                      && ((ntag_q == 2'd0 && cfg.outer_tag_aware_en)
                      || (ntag_q == 2'd1 && cfg.inner_tag_aware_en))) begin
                     ntag_d = ntag_q + 2'd1;
                  end else if (lenfld_q == 16'hffff) begin
                     lenfld_d = {hi_q, gmii_rxd};
                  end
               end
               if (cnt_q >= limit) begin
                  ovs_d = 1'b1;
               end
               if (st_q == GTM_DATA) begin
                  push = have_q;
                  hold_d = gmii_rxd;
                  have_d = 1'b1;
                  if (push && !fifo_rdy) begin
                     err_d = 1'b1;
                  end
                  if (cnt_q >= limit && cfg.length_error_drop_en) begin
                     st_d = GTM_DROP;
                  end
               end
            end else begin
               st_d = GTM_IDLE;
               push = have_q;
               // with length drop enabled, length errors mark the frame discarded
               push_word = '{err: err_q || (cfg.length_error_drop_en && frame_bad),
                             last: 1'b1, data: hold_q};
               if (cfg.length_error_drop_en && (ovs_q || in_range_err)) begin
                  drop_cnt_d = drop_cnt_q + 16'h0001;
               end
               if (ovs_q) begin
                  ovs_cnt_d = ovs_cnt_q + 16'h0001;
               end
            end
         end
         default: st_d = GTM_IDLE;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= GTM_IDLE;
         cnt_q <= '0;
         lenfld_q <= '0;
         hi_q <= '0;
         hold_q <= '0;
         ntag_q <= '0;
         ovs_q <= 1'b0;
         err_q <= 1'b0;
         have_q <= 1'b0;
         drop_cnt_q <= '0;
         ovs_cnt_q <= '0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         lenfld_q <= lenfld_d;
         hi_q <= hi_d;
         hold_q <= hold_d;
         ntag_q <= ntag_d;
         ovs_q <= ovs_d;
         err_q <= err_d;
         have_q <= have_d;
         drop_cnt_q <= drop_cnt_d;
         ovs_cnt_q <= ovs_cnt_d;
      end
   end
   gtm_fifo #(.WIDTH($bits(gtm_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_data(push_word),
      .in_valid(push),
      .in_ready(fifo_rdy),
      .out_data(rx_word),
      .out_valid(rx_valid),
      .out_ready(rx_ready)
   );
   // ==========================================
   // Assertions
   a_maxlen_reset: assert property (@(posedge aclk) !aresetn |=> maxlen_q == `GTM_RST_MAXLEN)
      else $error("max length reset wrong");
   a_outer_tpid: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q == GTM_DATA && gmii_rx_dv && cnt_q == `GTM_TYPE_POS && cfg.outer_tag_aware_en
      && ({hi_q, gmii_rxd} == `GTM_STD_TPID || {hi_q, gmii_rxd} == cfg.custom_tpid)
      |=> ntag_q == 2'd1)
      else $error("outer tag not seen");
   a_no_tags_off: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q != GTM_IDLE && gmii_rx_dv && cnt_q == `GTM_TYPE_POS && !cfg.outer_tag_aware_en
      |=> ntag_q == 2'd0)
      else $error("tag seen with awareness off");
   a_inner_off: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q != GTM_IDLE && ntag_q == 2'd1 && !cfg.inner_tag_aware_en |=> ntag_q != 2'd2)
      else $error("inner tag seen with awareness off");
   a_limit_adjust: assert property (@(posedge aclk) disable iff (!aresetn)
      ntag_q == 2'd2 && cfg.tag_length_allow_en |-> limit == cfg.max_frame_bytes + 16'h0008)
      else $error("double tag allowance wrong");
   a_drop_stops: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q == GTM_DROP && gmii_rx_dv |-> !push)
      else $error("dropped frame still forwarded");
   a_tx_gap_len: assert property (@(posedge aclk) disable iff (!aresetn)
      tx_frame_done && gap_q.tx_gap_len != 5'h00
      |=> busy_q && gap_cnt_q == $past(gap_q.tx_gap_len))
      else $error("tx gap not loaded");
   a_giga_fdx: assert property (@(posedge aclk) disable iff (!aresetn)
      gap_q.gigabit_speed_sel |-> $past(mode_q[`GTM_MODE_FDX]))
      else $error("gigabit without full duplex");
   a_ovs_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q != GTM_IDLE && gmii_rx_dv && cnt_q >= limit |=> ovs_q)
      else $error("oversize not flagged");
   a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write |=> bvalid_q && !awrdy_q && !wrdy_q)
      else $error("write response missing");
   c_write: cover property (@(posedge aclk) disable iff (!aresetn) do_write);
   c_double_tag: cover property (@(posedge aclk) disable iff (!aresetn) ntag_q == 2'd2);
   c_drop: cover property (@(posedge aclk) disable iff (!aresetn) st_q == GTM_DROP);
   c_fifo_full: cover property (@(posedge aclk) disable iff (!aresetn) !fifo_rdy);
endmodule
`default_nettype wire

// file: verification/gtm_phy_model.sv
// Physical layer model that sends framed bytes on the GMII receive lines
`timescale 1ns/10ps
`default_nettype none
module gtm_phy_model (
   // Clock
   input wire logic aclk,
   // GMII receive
   output logic [7:0] gmii_rxd,
   output logic gmii_rx_dv,
   output logic gmii_rx_er
);
   logic busy = 1'b0;
   initial {gmii_rxd, gmii_rx_dv, gmii_rx_er} = '0;
   // Idle data lines change every cycle so nothing stale looks valid
   always @(posedge aclk) if (!busy) gmii_rxd <= ~gmii_rxd;
   // Preamble, start delimiter, frame bytes, then at least one idle cycle
   task automatic send(input logic [7:0] f[$], input int er_at);
      int i;
      busy = 1'b1;
      for (i = -8; i < f.size(); i++) begin
         @(posedge aclk);
         gmii_rx_dv <= 1'b1;
         gmii_rxd <= (i < -1) ? 8'h55 : (i < 0) ? 8'hd5 : f[i];
         gmii_rx_er <= (i == er_at);
      end
      @(posedge aclk);
      gmii_rx_dv <= 1'b0;
      gmii_rx_er <= 1'b0;
      busy = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: verification/gtm_mac_cfg_tb.sv
// Self-checking bench of the tag, length and gap block
`timescale 1ns/10ps
`default_nettype none
module gtm_mac_cfg_tb;
   import gtm_pkg::*;
   logic aclk, aresetn, aw_v, aw_r, w_v, w_r, b_v, b_rd, ar_v, ar_r, r_v, r_rd;
   logic rx_valid, rx_ready, tx_done, gap_busy, dv, er;
   logic [11:0] aw_a, ar_a;
   logic [31:0] w_d, r_d;
   logic [1:0] b_resp, r_resp;
   logic [7:0] rxd;
   gtm_word_t rx_word;
   gtm_gap_t gap_cfg;
   logic [31:0] lf = 32'h8bc1;
   int failures, tests_run;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [2:0] fq[$];
   logic [7:0] dq[$];
   logic [11:0] ra[5] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014};
   logic [31:0] rv[5] = '{32'h11, 32'h5ee, 32'h81000004, 32'h0, 32'h715};
   logic [31:0] md[4] = '{32'h0, 32'h1, 32'h11, 32'h10};
   logic [31:0] gp[4] = '{32'h1987, 32'h13b7, 32'h715, 32'h13b7};

   gtm_mac_cfg #(.FIFO_DEPTH(32)) gtm_mac_cfg_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_resp),
      .s_axi_bvalid(b_v), .s_axi_bready(b_rd), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
      .s_axi_rready(r_rd), .gmii_rxd(rxd), .gmii_rx_dv(dv), .gmii_rx_er(er),
      .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .tx_frame_done(tx_done), .tx_gap_busy(gap_busy), .gap_cfg(gap_cfg));
   gtm_phy_model gtm_phy_model_i (.aclk(aclk), .gmii_rxd(rxd), .gmii_rx_dv(dv),
      .gmii_rx_er(er));

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   function automatic logic [7:0] rnd8();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf[7:0];
   endfunction
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
      bq.push_back(e);
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_rd <= 1'b1;
      do begin
         @(posedge aclk);
         if (aw_r) aw_v <= 1'b0;
         if (w_r) w_v <= 1'b0;
      end while (!b_v);
      b_rd <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
      rq.push_back({e, d});
      ar_a <= a;
      ar_v <= 1'b1;
      r_rd <= 1'b1;
      do begin
         @(posedge aclk);
         if (ar_r) ar_v <= 1'b0;
      end while (!r_v);
      r_rd <= 1'b0;
      @(posedge aclk);
   endtask
   // Note bits: check data, check error flag, expected error flag; t2 alone is the length field
   task automatic frame(input int n, input logic [15:0] t1, input logic [15:0] t2,
                        input logic [2:0] note, input int er_at);
      logic [7:0] f[$];
      int k;
      for (k = 0; k < n; k++) f.push_back(rnd8());
      k = t1 ? (t2 ? 20 : 16) : 12;
      f[12] = t1 ? t1[15:8] : f[12];
      f[13] = t1 ? t1[7:0] : f[13];
      f[16] = t2 ? t2[15:8] : f[16];
      f[17] = t2 ? t2[7:0] : f[17];
      f[k] = (t2 && !t1) ? t2[15:8] : 8'h08;
      f[k + 1] = (t2 && !t1) ? t2[7:0] : 8'h00;
      fq.push_back(note);
      if (note[2]) dq = {dq, f};
      gtm_phy_model_i.send(f, er_at);
      for (k = 0; k < 600 && fq.size() > 0; k++) @(posedge aclk);
      chk(fq.size(), 0);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge aclk) begin
      rx_ready <= rnd8() > 8'h40;
      if (r_v && r_rd) chk({r_resp, r_d}, rq.pop_front());
      if (b_v && b_rd) chk(b_resp, bq.pop_front());
      if (rx_valid && rx_ready) begin
         if (fq[0][2]) chk(rx_word.data, dq.pop_front());
         if (fq[0][2]) chk(rx_word.last, dq.size() == 0);
         if (rx_word.last && fq[0][1]) chk(rx_word.err, fq[0][0]);
         if (rx_word.last) void'(fq.pop_front());
      end
   end
   initial begin
      repeat (30000) @(posedge aclk);
      failures++;
      give_verdict();
   end
   initial begin
      int i;
      logic [7:0] n;
      {aresetn, aw_v, w_v, b_rd, ar_v, r_rd, rx_ready, tx_done, aw_a, ar_a, w_d} = '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (ra[j]) rd(ra[j], rv[j], 2'b00);
      rd(12'h040, 32'h0, 2'b10);
      wr(12'h040, 32'hffffffff, 2'b10);
      $display("test registers done");
      for (i = 0; i < 4; i++) begin
         wr(12'h004, md[i], 2'b00);
         wr(12'h014, gp[i], 2'b00);
         rd(12'h014, gp[i], 2'b00);
         repeat (3) @(posedge aclk);
         chk(gap_cfg, {gp[i][12:0], md[i][4] & md[i][0], md[i][0]});
         tx_done <= 1'b1;
         @(posedge aclk);
         tx_done <= 1'b0;
         n = 0;
         repeat (40) begin
            @(posedge aclk);
            n += gap_busy;
         end
         chk(n, gp[i][12:8]);
      end
      $display("test gaps done");
      wr(12'h008, 32'd64, 2'b00);
      wr(12'h00c, 32'h91000004, 2'b00);
      frame(64, 0, 0, 3'b110, -1);
      frame(68, 16'h8100, 0, 3'b110, -1);
      frame(40, 0, 0, 3'b011, 20);
      wr(12'h010, 32'h1, 2'b00);
      frame(65, 0, 0, 3'b011, -1);
      frame(68, 16'h8100, 0, 3'b011, -1);
      wr(12'h00c, 32'h91000005, 2'b00);
      frame(68, 16'h8100, 0, 3'b110, -1);
      frame(68, 16'h9100, 0, 3'b110, -1);
      frame(69, 16'h9100, 0, 3'b011, -1);
      frame(72, 16'h8100, 16'h9100, 3'b011, -1);
      wr(12'h00c, 32'h91000007, 2'b00);
      frame(72, 16'h9100, 16'h8100, 3'b110, -1);
      frame(73, 16'h8100, 16'h8100, 3'b011, -1);
      wr(12'h00c, 32'h91000003, 2'b00);
      frame(68, 16'h8100, 0, 3'b011, -1);
      frame(40, 0, 16'h0100, 3'b011, -1);
      wr(12'h030, 32'h0, 2'b00);
      rd(12'h030, 32'h0007_0007, 2'b00);
      $display("test frames done");
      give_verdict();
   end
endmodule
`default_nettype wire
